/* shared/sysctl_pkg.sv */
// Purpose: Shared constants and types for the system power and clock control block
// Assumes: Processor clock clk_sys at 250 MHz
// Notes:   Wake-up delay counts are derived from times in microseconds
package sysctl_pkg;
    // ========================================
    // Vector source selection
    localparam logic       VEC_FLASH      = 1'b0;
    localparam logic       VEC_SRAM       = 1'b1;
    localparam logic [31:0] VEC_BASE_ADDR = 32'h0000_0000;
    localparam int         VEC_BYTES      = 64;
    // ========================================
    // Peripheral clock divider codes
    localparam logic [1:0] DIV_QUARTER    = 2'h0;
    localparam logic [1:0] DIV_FULL       = 2'h1;
    localparam logic [1:0] DIV_HALF       = 2'h2;
    localparam logic [1:0] DIV_RESET      = DIV_QUARTER;
    // ========================================
    // Timing
    localparam int         CLK_MHZ        = 250;
    localparam int         OSC_WAIT_US    = 100;
    localparam int         OSC_WAIT_CYC   = OSC_WAIT_US * CLK_MHZ;
    localparam int         NUM_PERIPH     = 8;
    // ========================================
    // Power states
    typedef enum logic [2:0] {
        ST_RUN   = 3'b000,
        ST_IDLE  = 3'b001,
        ST_PDOWN = 3'b010,
        ST_WAKE  = 3'b011
    } power_state_type;
endpackage

/* design/periph_clock_divider.sv */
// Purpose: Produces the peripheral bus clock enable from the processor clock
// Assumes: Divider code from sysctl_pkg
// Notes:   Output is a one-cycle enable at the selected rate
`timescale 1ns/1ns
module periph_clock_divider (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic [1:0] div_sel,
    input  wire logic       run,
    output logic            tick
);
    logic [1:0] count;

    // ========================================
    // Divider counter
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            count <= 2'h0;
        end else if (!run) begin
            count <= 2'h0;
        end else begin
            count <= count + 2'h1;
        end
    end

    // ========================================
    // Rate select
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tick <= 1'b0;
        end else if (!run) begin
            tick <= 1'b0;
        end else begin
            unique case (div_sel)
                sysctl_pkg::DIV_FULL: tick <= 1'b1;                 // [R10]
                sysctl_pkg::DIV_HALF: tick <= (count[0] == 1'b1);   // [R10]
                default:              tick <= (count == 2'h3);      // [R10] [R11]
            endcase
        end
    end
endmodule

/* design/system_power_clock_remap_control.sv */
// Purpose: Vector remap, Idle and Power-down sequencing, peripheral gating, bus divider
// Assumes: Wake sources and oscillator ready arrive from outside the clock domain
// Notes:   Clock gating is expressed as enables for downstream clock gates
//
// Overview of operation
// R1: A remap control chooses which memory answers the vector area at address zero.
// R2: The vector source is either the bottom of flash or the on-chip SRAM.
// R3: Idle halts the processor until a reset or an interrupt arrives.
// R4: In Idle the peripheral clocks run while processor, memory and bus clocks stop.
// R5: Power-down stops the oscillator so no internal clock reaches any logic.
// R6: Power-down keeps all state and holds output pins at their last level.
// R7: Power-down ends on reset or on a clockless wake interrupt.
// R8: A real-time clock on the external slow clock keeps running in Power-down.
// R9: Each peripheral has its own clock enable under software control.
// R10: The peripheral bus clock runs at the processor rate, one half or one quarter.
// R11: After reset the peripheral bus clock runs at one quarter rate.
// R12: The PLL stays running through Idle if it was running before.
// R13: Each Power-down wake waits in the wake timer until the oscillator is stable.
// R14: Software requests modes with a mode bit and sets remap and divider first.
`timescale 1ns/1ns
module system_power_clock_remap_control #(
    parameter int NUM_PERIPH   = sysctl_pkg::NUM_PERIPH,
    parameter int OSC_WAIT_CYC = sysctl_pkg::OSC_WAIT_CYC
) (
    input  wire logic                  clk_sys,
    input  wire logic                  nrst,
    input  wire logic                  vec_src_sel,
    input  wire logic [1:0]            div_sel,
    input  wire logic [NUM_PERIPH-1:0] periph_enable,
    input  wire logic                  idle_request,
    input  wire logic                  pdown_request,
    input  wire logic                  irq_any,
    input  wire logic                  wake_irq,
    input  wire logic                  osc_ready,
    input  wire logic                  rtc_use_ext_clock,
    input  wire logic                  pll_running,
    input  wire logic [31:0]           fetch_addr,
    output logic                       vec_from_sram,
    output logic                       vec_hit,
    output logic                       cpu_clock_enable,
    output logic                       mem_bus_clock_enable,
    output logic [NUM_PERIPH-1:0]      periph_clock_enable,
    output logic                       peripheral_bus_tick,
    output logic                       osc_enable,
    output logic                       pll_keep,
    output logic                       rtc_clock_enable,
    output logic                       pin_hold,
    output logic [1:0]                 power_state
);
    sysctl_pkg::power_state_type state;
    logic                    wake_meta;
    logic                    wake_sync;
    logic                    osc_meta;
    logic                    osc_sync;
    logic                    irq_meta;
    logic                    irq_sync;
    logic [31:0]             wait_count;
    logic                    div_run;

    if (NUM_PERIPH < 1 || NUM_PERIPH > 32) begin : g_bad_num_periph
        $error("NUM_PERIPH out of range");
    end
    if (OSC_WAIT_CYC < 1) begin : g_bad_osc_wait
        $error("OSC_WAIT_CYC must be positive");
    end

    // ========================================
    // Synchronisers for outside inputs
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wake_meta <= 1'b0;
            wake_sync <= 1'b0;
            osc_meta  <= 1'b0;
            osc_sync  <= 1'b0;
            irq_meta  <= 1'b0;
            irq_sync  <= 1'b0;
        end else begin
            wake_meta <= wake_irq;
            wake_sync <= wake_meta;
            osc_meta  <= osc_ready;
            osc_sync  <= osc_meta;
            irq_meta  <= irq_any;
            irq_sync  <= irq_meta;
        end
    end

    // ========================================
    // Vector remap
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            vec_from_sram <= sysctl_pkg::VEC_FLASH;
        end else begin
            vec_from_sram <= (vec_src_sel == sysctl_pkg::VEC_SRAM);   // [R1] [R2] [R14]
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            vec_hit <= 1'b0;
        end else begin
            vec_hit <= (fetch_addr < (sysctl_pkg::VEC_BASE_ADDR
                        + 32'(sysctl_pkg::VEC_BYTES)));               // [R1]
        end
    end

    // ========================================
    // Power state machine
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state <= sysctl_pkg::ST_RUN;
        end else begin
            unique case (state)
                sysctl_pkg::ST_RUN: begin
                    if (pdown_request) begin
                        state <= sysctl_pkg::ST_PDOWN;                // [R14]
                    end else if (idle_request) begin
                        state <= sysctl_pkg::ST_IDLE;                 // [R14]
                    end
                end
                sysctl_pkg::ST_IDLE: begin
                    if (irq_sync) begin
                        state <= sysctl_pkg::ST_RUN;                  // [R3]
                    end
                end
                sysctl_pkg::ST_PDOWN: begin
                    if (wake_sync) begin
                        state <= sysctl_pkg::ST_WAKE;                 // [R7] [R13]
                    end
                end
                sysctl_pkg::ST_WAKE: begin
                    if (osc_sync && wait_count == 32'(OSC_WAIT_CYC - 1)) begin
                        state <= sysctl_pkg::ST_RUN;                  // [R13]
                    end
                end
                default: state <= sysctl_pkg::ST_RUN;
            endcase
        end
    end

    // ========================================
    // Wake-up timer
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wait_count <= 32'h0000_0000;
        end else if (state != sysctl_pkg::ST_WAKE || !osc_sync) begin
            wait_count <= 32'h0000_0000;                              // [R13]
        end else if (wait_count != 32'(OSC_WAIT_CYC - 1)) begin
            wait_count <= wait_count + 32'h0000_0001;
        end
    end

    // ========================================
    // Clock and hold controls
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cpu_clock_enable     <= 1'b1;
            mem_bus_clock_enable <= 1'b1;
            osc_enable           <= 1'b1;
            pin_hold             <= 1'b0;
            pll_keep             <= 1'b0;
            rtc_clock_enable     <= 1'b0;
        end else begin
            cpu_clock_enable     <= (state == sysctl_pkg::ST_RUN);    // [R3] [R4] [R13]
            mem_bus_clock_enable <= (state == sysctl_pkg::ST_RUN);    // [R4]
            osc_enable           <= (state != sysctl_pkg::ST_PDOWN);  // [R5]
            pin_hold             <= (state == sysctl_pkg::ST_PDOWN)
                                    || (state == sysctl_pkg::ST_WAKE); // [R6]
            pll_keep             <= pll_running
                                    && (state != sysctl_pkg::ST_PDOWN); // [R12]
            rtc_clock_enable     <= rtc_use_ext_clock
                                    || (state != sysctl_pkg::ST_PDOWN); // [R8]
        end
    end

    // ========================================
    // Peripheral enables, forced off in Power-down
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PERIPH; gi++) begin : g_periph
            always_ff @(posedge clk_sys or negedge nrst) begin
                if (!nrst) begin
                    periph_clock_enable[gi] <= 1'b1;
                end else if (state == sysctl_pkg::ST_PDOWN) begin
                    periph_clock_enable[gi] <= 1'b0;                  // [R5]
                end else begin
                    periph_clock_enable[gi] <= periph_enable[gi];     // [R9] [R4]
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            power_state <= 2'h0;
        end else begin
            power_state <= state[1:0];
        end
    end

    assign div_run = (state == sysctl_pkg::ST_RUN) || (state == sysctl_pkg::ST_IDLE); // [R4]

    // ========================================
    // Peripheral bus divider
    periph_clock_divider u_div (
        .clk_sys (clk_sys),
        .nrst    (nrst),
        .div_sel (div_sel),
        .run     (div_run),
        .tick    (peripheral_bus_tick)
    );
endmodule

/* verification/sysctl_asserts.sv */
// Purpose: Port checks for the power and clock control block
// Assumes: One clock domain, clk_sys
// Notes:   Attached by bind at the foot of this file
`timescale 1ns/1ns
module sysctl_asserts #(
    parameter int NUM_PERIPH   = 8,
    parameter int OSC_WAIT_CYC = 4
) (
    input wire logic                  clk_sys,
    input wire logic                  nrst,
    input wire logic                  vec_src_sel,
    input wire logic [1:0]            div_sel,
    input wire logic [NUM_PERIPH-1:0] periph_enable,
    input wire logic                  pll_running,
    input wire logic                  rtc_use_ext_clock,
    input wire logic                  vec_from_sram,
    input wire logic                  cpu_clock_enable,
    input wire logic [NUM_PERIPH-1:0] periph_clock_enable,
    input wire logic                  peripheral_bus_tick,
    input wire logic                  osc_enable,
    input wire logic                  pll_keep,
    input wire logic                  rtc_clock_enable,
    input wire logic                  pin_hold,
    input wire logic [1:0]            power_state
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    // ========================================
    // Assertions
    a_vec_follow: assert property ($past(nrst) |-> vec_from_sram == $past(vec_src_sel))
        else $error("vector source not followed");
    a_idle_halt: assert property (power_state == 2'h1 |-> !cpu_clock_enable && osc_enable)
        else $error("processor clock runs in idle");
    a_idle_periph: assert property (power_state == 2'h1 && $stable(periph_enable)
        |-> periph_clock_enable == periph_enable) else $error("peripheral clocks stop in idle");
    a_pdown_off: assert property (power_state == 2'h2
        |-> !osc_enable && pin_hold && periph_clock_enable == '0) else $error("clock in power-down");
    a_rtc_keep: assert property (power_state == 2'h2 && $stable(rtc_use_ext_clock)
        |-> rtc_clock_enable == rtc_use_ext_clock) else $error("rtc clock wrong in power-down");
    a_pll_idle: assert property (power_state == 2'h1 && $stable(pll_running)
        |-> pll_keep == pll_running) else $error("pll not kept in idle");
    a_wake_hold: assert property (power_state == 2'h3 |-> !cpu_clock_enable && pin_hold)
        else $error("execution before oscillator stable");
    a_div_quarter: assert property (peripheral_bus_tick && $past(div_sel) == 2'h0
        && $past(div_sel, 2) == 2'h0 && $past(div_sel, 3) == 2'h0 && $past(div_sel, 4) == 2'h0
        |-> !$past(peripheral_bus_tick) && !$past(peripheral_bus_tick, 2)
        && !$past(peripheral_bus_tick, 3)) else $error("quarter rate");
    a_div_half: assert property (peripheral_bus_tick && div_sel == 2'h2 && $stable(div_sel)
        && $past(div_sel, 2) == div_sel |=> !peripheral_bus_tick) else $error("half rate");
    c_idle: cover property (power_state == 2'h1);
    c_pdown: cover property (power_state == 2'h2);
    c_wake: cover property (power_state == 2'h3);
    c_pdown_rtc_off: cover property (power_state == 2'h2 && !rtc_use_ext_clock);
endmodule
bind system_power_clock_remap_control sysctl_asserts #(
    .NUM_PERIPH(NUM_PERIPH), .OSC_WAIT_CYC(OSC_WAIT_CYC)) u_sysctl_asserts (
    .clk_sys, .nrst, .vec_src_sel, .div_sel, .periph_enable, .pll_running, .rtc_use_ext_clock,
    .vec_from_sram, .cpu_clock_enable, .periph_clock_enable, .peripheral_bus_tick,
    .osc_enable, .pll_keep, .rtc_clock_enable, .pin_hold, .power_state);

/* verification/osc_model.sv */
// Purpose: Crystal oscillator start-up model
// Assumes: Enable comes from the control block
// Notes:   Ready drops at once when stopped
`timescale 1ns/1ns
module osc_model (
    input  wire logic       clk_sys,
    input  wire logic       osc_enable,
    input  wire logic [7:0] start_cycles,
    output logic            osc_ready = 1'h0
);
    logic [7:0] cnt = 8'h00;
    always @(posedge clk_sys) begin
        // Saturate so ready never drops by wrap-around
        cnt <= !osc_enable ? 8'h00 : ((cnt == 8'hff) ? cnt : cnt + 8'h01);
        osc_ready <= osc_enable && cnt >= start_cycles;
    end
endmodule

/* verification/tb_system_power_clock_remap_control.sv */
// Purpose: Self-checking bench for the power and clock control block
// Assumes: Inputs driven at the falling edge
// Notes:   Short oscillator wait count
`timescale 1ns/1ns
module tb_system_power_clock_remap_control;
    localparam int OW = 6;
    logic        clk_sys = 1'h0, nrst = 1'h0, vec_src_sel = 1'h0, idle_request = 1'h0;
    logic        pdown_request = 1'h0, irq_any = 1'h0, wake_irq = 1'h0;
    logic        rtc_use_ext_clock = 1'h1, pll_running = 1'h1, osc_ready;
    logic [1:0]  div_sel = 2'h0, power_state;
    logic [7:0]  periph_enable = 8'hff, periph_clock_enable;
    logic [31:0] fetch_addr = 32'h0000_0000;
    logic        vec_from_sram, vec_hit, cpu_clock_enable, mem_bus_clock_enable;
    logic        peripheral_bus_tick, osc_enable, pll_keep, rtc_clock_enable, pin_hold;
    int          n_mismatch = 0, checked = 0, cycles = 0, n;
    int          ticks_exp[4] = '{4, 16, 8, 4};
    system_power_clock_remap_control #(.NUM_PERIPH(8), .OSC_WAIT_CYC(OW))
        u_system_power_clock_remap_control (.clk_sys, .nrst, .vec_src_sel, .div_sel,
        .periph_enable, .idle_request, .pdown_request, .irq_any, .wake_irq, .osc_ready,
        .rtc_use_ext_clock, .pll_running, .fetch_addr, .vec_from_sram, .vec_hit,
        .cpu_clock_enable, .mem_bus_clock_enable, .periph_clock_enable,
        .peripheral_bus_tick, .osc_enable, .pll_keep, .rtc_clock_enable, .pin_hold,
        .power_state);
    osc_model u_osc_model (.clk_sys, .osc_enable, .start_cycles(8'h0a), .osc_ready);
    initial forever #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic count_ticks(output int c);
        c = 0;
        repeat (16) @(negedge clk_sys) c += (peripheral_bus_tick === 1'h1);
    endtask
    task automatic wait_state(input logic [1:0] s, output int c);
        c = 0;
        while (power_state !== s && c < 500) begin
            @(negedge clk_sys);
            c++;
        end
        check("power_state", s, power_state);
    endtask
    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge clk_sys);
        nrst = 1'h1;
        @(negedge clk_sys);
        check("periph_clock_enable", 8'hff, periph_clock_enable);
        for (int i = 0; i < 4; i++) begin
            div_sel = i[1:0];
            repeat (2) @(negedge clk_sys);
            count_ticks(n);
            check("ticks", ticks_exp[i], n);
        end
        $display("test divider done");
        vec_src_sel = 1'h1;
        fetch_addr = 32'h0000_003c;
        repeat (2) @(negedge clk_sys);
        check("vec_from_sram", 1'h1, vec_from_sram);
        check("vec_hit", 1'h1, vec_hit);
        fetch_addr = 32'h0000_0040;
        repeat (2) @(negedge clk_sys);
        check("vec_hit", 1'h0, vec_hit);
        $display("test remap done");
        periph_enable = 8'h5a;
        idle_request = 1'h1;
        @(negedge clk_sys) idle_request = 1'h0;
        wait_state(2'h1, n);
        check("mem_bus_clock_enable", 1'h0, mem_bus_clock_enable);
        check("periph_clock_enable", 8'h5a, periph_clock_enable);
        check("pll_keep", 1'h1, pll_keep);
        count_ticks(n);
        check("idle ticks", 32'h0000_0004, n);
        irq_any = 1'h1;
        wait_state(2'h0, n);
        irq_any = 1'h0;
        @(negedge clk_sys);
        check("cpu_clock_enable", 1'h1, cpu_clock_enable);
        $display("test idle done");
        idle_request = 1'h1;
        pdown_request = 1'h1;
        @(negedge clk_sys) {idle_request, pdown_request} = 2'h0;
        wait_state(2'h2, n);
        check("pin_hold", 1'h1, pin_hold);
        check("rtc_clock_enable", 1'h1, rtc_clock_enable);
        irq_any = 1'h1;
        repeat (8) @(negedge clk_sys);
        irq_any = 1'h0;
        check("power_state", 2'h2, power_state);
        wake_irq = 1'h1;
        wait_state(2'h3, n);
        wake_irq = 1'h0;
        wait_state(2'h0, n);
        check("wake wait", 1'h1, n >= 10 + OW);
        @(negedge clk_sys);
        check("pin_hold", 1'h0, pin_hold);
        $display("test power-down done");
        rtc_use_ext_clock = 1'h0;
        pll_running = 1'h0;
        pdown_request = 1'h1;
        @(negedge clk_sys) pdown_request = 1'h0;
        wait_state(2'h2, n);
        check("rtc_clock_enable", 1'h0, rtc_clock_enable);
        check("pll_keep", 1'h0, pll_keep);
        check("osc_enable", 1'h0, osc_enable);
        check("vec_from_sram", 1'h1, vec_from_sram);
        wake_irq = 1'h1;
        wait_state(2'h3, n);
        wake_irq = 1'h0;
        check("osc_enable", 1'h1, osc_enable);
        wait_state(2'h0, n);
        check("wake wait", 1'h1, n >= 10 + OW);
        $display("test power-down without rtc done");
        end_sim();
    end
endmodule
